// >>> rtl/irq_ctrl_map.svh
// register map, field positions, reset values and vectors of the interrupt controller
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH
// ==========================================
// register offsets and reset values
`define SRC_EN_ADDR      8'hA8
`define SEC_EN_PRIO_ADDR 8'hA9
`define PRIO_LEVEL_ADDR  8'hB8
`define SRC_EN_RESET     8'h00
`define SEC_EN_PRIO_RESET 8'hA0
`define PRIO_LEVEL_RESET 8'h00
// ==========================================
// field positions
`define MASTER_EN_BIT    3'd7
`define SEC_TIC_PRIO     6
`define SEC_PSM_PRIO     5
`define SEC_SSI_PRIO     4
`define SEC_TIC_EN       2
`define SEC_PSM_EN       1
`define SEC_SSI_EN       0
// ==========================================
// polling positions, 0 is served first
`define NUM_SRC          11
`define POLL_PSM         4'd0
`define POLL_WDT         4'd1
`define POLL_EXT0        4'd2
`define POLL_ADC         4'd3
`define POLL_T0          4'd4
`define POLL_EXT1        4'd5
`define POLL_T1          4'd6
`define POLL_SSI         4'd7
`define POLL_UART        4'd8
`define POLL_T2          4'd9
`define POLL_TIC         4'd10
// ==========================================
// vector addresses
`define VEC_EXT0         16'h0003
`define VEC_T0           16'h000B
`define VEC_EXT1         16'h0013
`define VEC_T1           16'h001B
`define VEC_UART         16'h0023
`define VEC_T2           16'h002B
`define VEC_ADC          16'h0033
`define VEC_SSI          16'h003B
`define VEC_PSM          16'h0043
`define VEC_TIC          16'h0053
`define VEC_WDT          16'h005B
`endif

// >>> rtl/irq_ctrl_pkg.sv
// types shared by the interrupt controller and its surroundings
package irq_ctrl_pkg;
   // raw request flags from the peripherals and the core
   typedef struct packed {
      logic supply_monitor_flag;
      logic watchdog_irq_flag;
      logic ext0_request_flag;
      logic adc_primary_ready;
      logic adc_aux_ready;
      logic timer0_overflow_flag;
      logic ext1_request_flag;
      logic timer1_overflow_flag;
      logic spi_done_flag;
      logic i2c_done_flag;
      logic uart_rx_done_flag;
      logic uart_tx_done_flag;
      logic timer2_overflow_flag;
      logic timer2_external_flag;
      logic interval_counter_flag;
   } src_flags_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       bit_wr;
      logic [2:0] bit_sel;
      logic       bit_val;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_PUSH_LO = 2'b01,
      ST_PUSH_HI = 2'b10,
      ST_LOAD    = 2'b11
   } seq_state_t;
endpackage : irq_ctrl_pkg

// >>> rtl/two_level_irq_controller.sv
// two-level interrupt controller: enables, priorities, polling, vector sequence
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.svh"
module two_level_irq_controller (
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   input  wire logic                    ce_i,
   input  wire irq_ctrl_pkg::sfr_req_t  sfr_i,
   output logic [7:0]                   sfr_rdata_o,
   input  wire irq_ctrl_pkg::src_flags_t flags_i,
   input  wire logic                    watchdog_irq_mode_i,
   input  wire logic [3:0]              watchdog_timeout_i,
   input  wire logic [15:0]             pc_i,
   input  wire logic                    irq_ack_i,
   input  wire logic                    reti_i,
   output logic                         irq_req_o,
   output logic [15:0]                  irq_vector_o,
   output logic                         stack_push_o,
   output logic [7:0]                   stack_data_o,
   output logic                         pc_load_o,
   output logic [15:0]                  pc_load_value_o,
   output logic [3:0]                   taken_source_o,
   output logic [1:0]                   in_service_o
);
   // ==========================================
   // registers
   logic [7:0]              src_enable_reg;
   logic [7:0]              sec_en_prio_reg;
   logic [7:0]              prio_level_reg;
   logic [7:0]              rdata_reg;
   logic [1:0]              in_service_reg;
   irq_ctrl_pkg::seq_state_t state_reg;
   irq_ctrl_pkg::seq_state_t state_next;
   logic                    cand_valid_reg;
   logic                    cand_high_reg;
   logic [3:0]              cand_idx_reg;
   logic [15:0]             vector_reg;
   logic [15:0]             load_value_reg;
   logic [7:0]              pc_hi_reg;
   logic [7:0]              stack_data_reg;
   logic [3:0]              taken_reg;

   // ==========================================
   // register access decode
   wire sel_src = sfr_i.addr == `SRC_EN_ADDR;
   wire sel_sec = sfr_i.addr == `SEC_EN_PRIO_ADDR;
   wire sel_pri = sfr_i.addr == `PRIO_LEVEL_ADDR;
   // only the two classic registers answer bit writes
   wire bit_src = sfr_i.bit_wr && sel_src;
   wire bit_pri = sfr_i.bit_wr && sel_pri;
   wire [7:0] bit_mask = 8'h01 << sfr_i.bit_sel;
   wire [7:0] bit_fill = {8{sfr_i.bit_val}};
   wire [7:0] rd_mux =
      sel_src ? src_enable_reg :
      sel_sec ? sec_en_prio_reg :
      sel_pri ? {1'b0, prio_level_reg[6:0]} :
      8'h00;

   // ==========================================
   // request, enable and level vectors in polling order
   // shared sources merge both of their flags
   logic [`NUM_SRC-1:0] pend;
   logic [`NUM_SRC-1:0] enab;
   logic [`NUM_SRC-1:0] high;
   wire ea = src_enable_reg[`MASTER_EN_BIT];
   wire wdt_pend = flags_i.watchdog_irq_flag && watchdog_irq_mode_i
                   && (watchdog_timeout_i != 4'h0);

   assign pend = {
      flags_i.interval_counter_flag,
      flags_i.timer2_overflow_flag | flags_i.timer2_external_flag,
      flags_i.uart_rx_done_flag | flags_i.uart_tx_done_flag,
      flags_i.spi_done_flag | flags_i.i2c_done_flag,
      flags_i.timer1_overflow_flag,
      flags_i.ext1_request_flag,
      flags_i.timer0_overflow_flag,
      flags_i.adc_primary_ready | flags_i.adc_aux_ready,
      flags_i.ext0_request_flag,
      wdt_pend,
      flags_i.supply_monitor_flag};

   // watchdog is enabled whenever it requests, even with the master gate off
   assign enab = {
      sec_en_prio_reg[`SEC_TIC_EN],
      src_enable_reg[5],
      src_enable_reg[4],
      sec_en_prio_reg[`SEC_SSI_EN],
      src_enable_reg[3],
      src_enable_reg[2],
      src_enable_reg[1],
      src_enable_reg[6],
      src_enable_reg[0],
      1'b1,
      sec_en_prio_reg[`SEC_PSM_EN]};

   assign high = {
      sec_en_prio_reg[`SEC_TIC_PRIO],
      prio_level_reg[5],
      prio_level_reg[4],
      sec_en_prio_reg[`SEC_SSI_PRIO],
      prio_level_reg[3],
      prio_level_reg[2],
      prio_level_reg[1],
      prio_level_reg[6],
      prio_level_reg[0],
      1'b1,
      sec_en_prio_reg[`SEC_PSM_PRIO]};

   // master gate applies to every source except the watchdog
   logic [`NUM_SRC-1:0] gate;
   genvar g;
   generate
      for (g = 0; g < `NUM_SRC; g = g + 1) begin : g_gate
         if (g == `POLL_WDT) begin : g_wdt
            assign gate[g] = pend[g] && enab[g];
         end else begin : g_mask
            assign gate[g] = pend[g] && enab[g] && ea;
         end
      end
   endgenerate

   // lowest set index wins: that is the polling order
   function automatic logic [3:0] first_set(input logic [`NUM_SRC-1:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = `NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction : first_set

   function automatic logic [15:0] vec_of(input logic [3:0] idx);
      case (idx)
         `POLL_PSM:  return `VEC_PSM;
         `POLL_WDT:  return `VEC_WDT;
         `POLL_EXT0: return `VEC_EXT0;
         `POLL_ADC:  return `VEC_ADC;
         `POLL_T0:   return `VEC_T0;
         `POLL_EXT1: return `VEC_EXT1;
         `POLL_T1:   return `VEC_T1;
         `POLL_SSI:  return `VEC_SSI;
         `POLL_UART: return `VEC_UART;
         `POLL_T2:   return `VEC_T2;
         `POLL_TIC:  return `VEC_TIC;
         default:    return 16'h0000;
      endcase
   endfunction : vec_of

   wire [`NUM_SRC-1:0] hi_req = gate & high;
   wire [`NUM_SRC-1:0] lo_req = gate & ~high;
   // a level may only interrupt when nothing at its level or above runs
   wire hi_ok = (|hi_req) && !in_service_reg[1];
   wire lo_ok = (|lo_req) && (in_service_reg == 2'b00);
   wire cand_valid = hi_ok || lo_ok;
   wire cand_high = hi_ok;
   wire [3:0] cand_idx = hi_ok ? first_set(hi_req) : first_set(lo_req);
   // take works from the registered candidate: a source that drops its flag
   // in the acknowledge cycle is still taken, so the core may clear it early
   wire take = (state_reg == irq_ctrl_pkg::ST_IDLE) && cand_valid_reg && irq_ack_i;

   // ==========================================
   // vectoring sequence: push low byte, push high byte, then load
   always_comb begin
      case (state_reg)
         irq_ctrl_pkg::ST_IDLE:
            state_next = take ? irq_ctrl_pkg::ST_PUSH_LO : irq_ctrl_pkg::ST_IDLE;
         irq_ctrl_pkg::ST_PUSH_LO: state_next = irq_ctrl_pkg::ST_PUSH_HI;
         irq_ctrl_pkg::ST_PUSH_HI: state_next = irq_ctrl_pkg::ST_LOAD;
         irq_ctrl_pkg::ST_LOAD:    state_next = irq_ctrl_pkg::ST_IDLE;
         default:                  state_next = irq_ctrl_pkg::ST_IDLE;
      endcase
   end

   // ==========================================
   // configuration registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         src_enable_reg  <= `SRC_EN_RESET;
         sec_en_prio_reg <= `SEC_EN_PRIO_RESET;
         prio_level_reg  <= `PRIO_LEVEL_RESET;
      end else if (ce_i) begin
         if (sfr_i.wr && sel_src) begin
            src_enable_reg <= sfr_i.wdata;
         end else if (bit_src) begin
            src_enable_reg <= (src_enable_reg & ~bit_mask) | (bit_fill & bit_mask);
         end
         // bit 3 is stored as written; software keeps it zero
         if (sfr_i.wr && sel_sec) begin
            sec_en_prio_reg <= sfr_i.wdata;
         end
         if (sfr_i.wr && sel_pri) begin
            prio_level_reg <= {1'b0, sfr_i.wdata[6:0]};
         end else if (bit_pri) begin
            prio_level_reg <= ((prio_level_reg & ~bit_mask) | (bit_fill & bit_mask))
                              & 8'h7F;
         end
      end
   end

   // ==========================================
   // read data, held until the next read strobe
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
      end else if (ce_i && sfr_i.rd) begin
         rdata_reg <= rd_mux;
      end
   end

   // ==========================================
   // arbitration result, registered so vector and request line up
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cand_valid_reg <= 1'b0;
         cand_high_reg  <= 1'b0;
         cand_idx_reg   <= 4'h0;
         vector_reg     <= 16'h0000;
      end else if (ce_i) begin
         cand_valid_reg <= cand_valid && !take;
         cand_high_reg  <= cand_high;
         cand_idx_reg   <= cand_idx;
         vector_reg     <= vec_of(cand_idx);
      end
   end

   // ==========================================
   // sequence state
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= irq_ctrl_pkg::ST_IDLE;
      end else if (ce_i) begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // snapshot at the take edge
   // pc_i keeps moving, so both bytes are caught at once and the high one
   // waits a cycle for its push slot
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_hi_reg      <= 8'h00;
         stack_data_reg <= 8'h00;
         load_value_reg <= 16'h0000;
         taken_reg      <= 4'h0;
      end else if (ce_i) begin
         if (take) begin
            stack_data_reg <= pc_i[7:0];
            pc_hi_reg      <= pc_i[15:8];
            load_value_reg <= vector_reg;
            taken_reg      <= cand_idx_reg;
         end else if (state_reg == irq_ctrl_pkg::ST_PUSH_LO) begin
            stack_data_reg <= pc_hi_reg;
         end
      end
   end

   // ==========================================
   // in-service tracking
   // a return ends the innermost level; a take in the same cycle wins,
   // which the core avoids since it only returns outside the sequence
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         in_service_reg <= 2'b00;
      end else if (ce_i) begin
         if (take) begin
            if (cand_high_reg) begin
               in_service_reg[1] <= 1'b1;
            end else begin
               in_service_reg[0] <= 1'b1;
            end
         end else if (reti_i) begin
            if (in_service_reg[1]) begin
               in_service_reg[1] <= 1'b0;
            end else begin
               in_service_reg[0] <= 1'b0;
            end
         end
      end
   end

   // ==========================================
   // outputs
   assign irq_req_o       = (state_reg == irq_ctrl_pkg::ST_IDLE) && cand_valid_reg;
   assign irq_vector_o    = vector_reg;
   assign stack_push_o    = (state_reg == irq_ctrl_pkg::ST_PUSH_LO) ||
                            (state_reg == irq_ctrl_pkg::ST_PUSH_HI);
   assign stack_data_o    = stack_data_reg;
   assign pc_load_o       = state_reg == irq_ctrl_pkg::ST_LOAD;
   assign pc_load_value_o = load_value_reg;
   assign taken_source_o  = taken_reg;
   assign in_service_o    = in_service_reg;
   assign sfr_rdata_o     = rdata_reg;
endmodule : two_level_irq_controller
`default_nettype wire

// >>> tb/irq_core_model.sv
// behavioural core: accepts requests, runs its pc, collects pushed bytes
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        accept_i,
   input  wire logic        irq_req_i,
   input  wire logic        stack_push_i,
   input  wire logic [7:0]  stack_data_i,
   output logic             irq_ack_o,
   output logic [15:0]      pc_o,
   output logic [15:0]      take_pc_o,
   output logic [15:0]      pushed_o
);
   // accept low models a core that is slow to respond
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_ack_o <= 1'b0;
         pc_o      <= 16'h1234;
         take_pc_o <= 16'h0000;
         pushed_o  <= 16'h0000;
      end else begin
         irq_ack_o <= accept_i && irq_req_i && !irq_ack_o;
         pc_o      <= pc_o + 16'h0135;
         if (irq_req_i && irq_ack_o) take_pc_o <= pc_o;
         if (stack_push_i) pushed_o <= {stack_data_i, pushed_o[15:8]};
      end
   end
endmodule : irq_core_model
`default_nettype wire

// >>> tb/irq_ctrl_properties.sv
// port-level assertions for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_properties (
   input wire logic                     clk_i,
   input wire logic                     rst_i,
   input wire logic                     ce_i,
   input wire irq_ctrl_pkg::src_flags_t flags_i,
   input wire logic                     watchdog_irq_mode_i,
   input wire logic [3:0]               watchdog_timeout_i,
   input wire logic [15:0]              pc_i,
   input wire logic                     irq_ack_i,
   input wire logic                     reti_i,
   input wire logic                     irq_req_o,
   input wire logic [15:0]              irq_vector_o,
   input wire logic                     stack_push_o,
   input wire logic [7:0]               stack_data_o,
   input wire logic                     pc_load_o,
   input wire logic [15:0]              pc_load_value_o,
   input wire logic [1:0]               in_service_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic  take = irq_req_o && irq_ack_i && ce_i;
   logic [15:0] pc_q;
   logic [15:0] vec_q;
   // snapshot at the take edge, pc_i keeps moving while bytes are pushed
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pc_q  <= 16'h0000;
         vec_q <= 16'h0000;
      end else if (take) begin
         pc_q  <= pc_i;
         vec_q <= irq_vector_o;
      end
   end
   // ==========================================
   // vector sequence and level tracking
   property p_push_lo; take |=> stack_push_o && stack_data_o == pc_q[7:0]; endproperty
   property p_push_hi; take |=> ##1 stack_push_o && stack_data_o == pc_q[15:8]; endproperty
   property p_load; take |=> ##2 pc_load_o && pc_load_value_o == vec_q ##1 !pc_load_o; endproperty
   property p_quiet; take |=> !irq_req_o [*3]; endproperty
   property p_vec;
      irq_req_o |-> irq_vector_o inside {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
         16'h002B, 16'h0033, 16'h003B, 16'h0043, 16'h0053, 16'h005B};
   endproperty
   property p_wdt;
      irq_req_o && irq_vector_o == 16'h005B |-> $past(flags_i.watchdog_irq_flag)
         && $past(watchdog_irq_mode_i) && $past(watchdog_timeout_i) != 4'h0;
   endproperty
   property p_high_busy; in_service_o[1] |-> !irq_req_o; endproperty
   property p_preempt; take && in_service_o == 2'b01 |=> in_service_o == 2'b11; endproperty
   property p_reti; reti_i && !take && in_service_o == 2'b11 |=> in_service_o == 2'b01; endproperty
   a_push_lo: assert property (p_push_lo) else $error("low pc byte not pushed");
   a_push_hi: assert property (p_push_hi) else $error("high pc byte not pushed");
   a_load: assert property (p_load) else $error("vector load wrong");
   a_quiet: assert property (p_quiet) else $error("request during sequence");
   a_vec: assert property (p_vec) else $error("vector not in table");
   a_wdt: assert property (p_wdt) else $error("watchdog request without cause");
   a_high_busy: assert property (p_high_busy) else $error("high level preempted");
   a_preempt: assert property (p_preempt) else $error("nesting not tracked");
   a_reti: assert property (p_reti) else $error("return cleared wrong level");
   c_take: cover property (take);
   c_nest: cover property (in_service_o == 2'b11);
   c_wdt: cover property (pc_load_o && pc_load_value_o == 16'h005B);
endmodule : irq_ctrl_properties
bind two_level_irq_controller irq_ctrl_properties i_irq_ctrl_properties (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .flags_i(flags_i),
   .watchdog_irq_mode_i(watchdog_irq_mode_i), .watchdog_timeout_i(watchdog_timeout_i),
   .pc_i(pc_i), .irq_ack_i(irq_ack_i), .reti_i(reti_i), .irq_req_o(irq_req_o),
   .irq_vector_o(irq_vector_o), .stack_push_o(stack_push_o), .stack_data_o(stack_data_o),
   .pc_load_o(pc_load_o), .pc_load_value_o(pc_load_value_o), .in_service_o(in_service_o));
`default_nettype wire

// >>> tb/two_level_irq_controller_tb.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module two_level_irq_controller_tb;
   typedef struct {logic [7:0] ie; logic [7:0] e2; logic [7:0] ip; logic [14:0] fl;
      logic [15:0] vec;} row_t;
   logic clk, rst, ce, accept, reti, ack, req, push, load, wdt_mode;
   logic [3:0]  wdt_to, tsrc;
   logic [1:0]  insvc;
   logic [7:0]  rdata, sdata;
   logic [15:0] pc, tpc, pushed, vector, loadv;
   irq_ctrl_pkg::sfr_req_t   sfr;
   irq_ctrl_pkg::src_flags_t flags;
   int err_count = 0;
   int checked = 0;
   // second byte kept with bit 3 at zero as software must
   row_t rows[20] = '{
      '{8'h81, 8'hA0, 8'h00, 15'h1000, 16'h0003}, '{8'h82, 8'hA0, 8'h00, 15'h0200, 16'h000B},
      '{8'h84, 8'hA0, 8'h00, 15'h0100, 16'h0013}, '{8'h88, 8'hA0, 8'h00, 15'h0080, 16'h001B},
      '{8'h90, 8'hA0, 8'h00, 15'h0010, 16'h0023}, '{8'h90, 8'hA0, 8'h00, 15'h0008, 16'h0023},
      '{8'hA0, 8'hA0, 8'h00, 15'h0004, 16'h002B}, '{8'hA0, 8'hA0, 8'h00, 15'h0002, 16'h002B},
      '{8'hC0, 8'hA0, 8'h00, 15'h0400, 16'h0033}, '{8'h80, 8'hA1, 8'h00, 15'h0020, 16'h003B},
      '{8'h80, 8'hA2, 8'h00, 15'h4000, 16'h0043}, '{8'h80, 8'hA4, 8'h00, 15'h0001, 16'h0053},
      '{8'h00, 8'hA0, 8'h00, 15'h2000, 16'h005B}, '{8'h7F, 8'h07, 8'h00, 15'h5FFF, 16'h0000},
      '{8'hFF, 8'hA7, 8'h00, 15'h5FFF, 16'h0043}, '{8'hFF, 8'h07, 8'h00, 15'h1FFF, 16'h0003},
      '{8'hFF, 8'h44, 8'h00, 15'h1C01, 16'h0053}, '{8'hFF, 8'h11, 8'h00, 15'h0240, 16'h003B},
      '{8'h80, 8'h02, 8'h00, 15'h6000, 16'h005B}, '{8'hBF, 8'h00, 8'h00, 15'h0A00, 16'h000B}};
   two_level_irq_controller i_two_level_irq_controller (.clk_i(clk), .rst_i(rst), .ce_i(ce),
      .sfr_i(sfr), .sfr_rdata_o(rdata), .flags_i(flags), .watchdog_irq_mode_i(wdt_mode),
      .watchdog_timeout_i(wdt_to), .pc_i(pc), .irq_ack_i(ack), .reti_i(reti),
      .irq_req_o(req), .irq_vector_o(vector), .stack_push_o(push), .stack_data_o(sdata),
      .pc_load_o(load), .pc_load_value_o(loadv), .taken_source_o(tsrc), .in_service_o(insvc));
   irq_core_model i_irq_core_model (.clk_i(clk), .rst_i(rst), .accept_i(accept),
      .irq_req_i(req), .stack_push_i(push), .stack_data_i(sdata), .irq_ack_o(ack),
      .pc_o(pc), .take_pc_o(tpc), .pushed_o(pushed));
   // polling position of the source behind each vector
   function automatic logic [3:0] exp_src(input logic [15:0] v);
      case (v)
         16'h0043: return 4'd0;
         16'h005B: return 4'd1;
         16'h0003: return 4'd2;
         16'h0033: return 4'd3;
         16'h000B: return 4'd4;
         16'h0013: return 4'd5;
         16'h001B: return 4'd6;
         16'h003B: return 4'd7;
         16'h0023: return 4'd8;
         16'h002B: return 4'd9;
         default:  return 4'd10;
      endcase
   endfunction : exp_src
   // ==========================================
   // bus and link tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr.wr <= 1'b1;
      sfr.addr <= a;
      sfr.wdata <= d;
      @(posedge clk);
      sfr.wr <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      sfr.rd <= 1'b1;
      sfr.addr <= a;
      @(posedge clk);
      sfr.rd <= 1'b0;
      #1 `CHK(rdata, e);
   endtask : rd_chk
   task automatic set_flags(input logic [14:0] f);
      @(posedge clk);
      flags <= f;
      repeat (3) @(posedge clk);
      #1;
   endtask : set_flags
   task automatic take_chk(input logic [15:0] v);
      int n;
      n = 0;
      @(posedge clk);
      accept <= 1'b1;
      do begin @(posedge clk); #1 n++; end while (!load && n < 20);
      `CHK(loadv, v);
      `CHK(pushed, tpc);
      `CHK(tsrc, exp_src(v));
      @(posedge clk);
      accept <= 1'b0;
   endtask : take_chk
   task automatic reti_pulse(input logic [1:0] e);
      @(posedge clk);
      reti <= 1'b1;
      @(posedge clk);
      reti <= 1'b0;
      @(posedge clk);
      #1 `CHK(insvc, e);
   endtask : reti_pulse
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #400000;
      err_count++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      sfr = '0;
      flags = '0;
      accept = 1'b0;
      reti = 1'b0;
      wdt_mode = 1'b1;
      wdt_to = 4'h3;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd_chk(8'hA8, 8'h00);
      rd_chk(8'hA9, 8'hA0);
      rd_chk(8'hB8, 8'h00);
      $display("reset values done");
      foreach (rows[i]) begin
         wr(8'hA8, rows[i].ie);
         wr(8'hA9, rows[i].e2);
         wr(8'hB8, rows[i].ip);
         set_flags(rows[i].fl);
         `CHK(req, rows[i].vec != 16'h0000);
         if (rows[i].vec != 16'h0000) begin
            `CHK(vector, rows[i].vec);
            take_chk(rows[i].vec);
         end
         set_flags(15'h0000);
         reti_pulse(2'b00);
         $display("row %0d done", i);
      end
      // low ext0 in service, then low timer0 waits and high ext1 preempts
      wr(8'hA8, 8'h87);
      wr(8'hA9, 8'h00);
      wr(8'hB8, 8'h04);
      set_flags(15'h1000);
      take_chk(16'h0003);
      set_flags(15'h1200);
      `CHK(insvc, 2'b01);
      `CHK(req, 1'b0);
      set_flags(15'h1300);
      `CHK(vector, 16'h0013);
      take_chk(16'h0013);
      set_flags(15'h0000);
      `CHK(insvc, 2'b11);
      reti_pulse(2'b01);
      reti_pulse(2'b00);
      $display("preemption done");
      wdt_mode <= 1'b0;
      set_flags(15'h2000);
      `CHK(req, 1'b0);
      wdt_mode <= 1'b1;
      wdt_to <= 4'h0;
      set_flags(15'h2000);
      `CHK(req, 1'b0);
      set_flags(15'h0000);
      $display("watchdog gating done");
      // clock enable low freezes arbitration, so no request appears
      ce <= 1'b0;
      set_flags(15'h1000);
      `CHK(req, 1'b0);
      ce <= 1'b1;
      set_flags(15'h1000);
      `CHK(req, 1'b1);
      `CHK(vector, 16'h0003);
      set_flags(15'h0000);
      $display("clock enable done");
      rd_chk(8'hAA, 8'h00);
      wr(8'hB8, 8'hFF);
      rd_chk(8'hB8, 8'h7F);
      wr(8'hA8, 8'h00);
      @(posedge clk);
      sfr.bit_wr <= 1'b1;
      sfr.addr <= 8'hA8;
      sfr.bit_sel <= 3'd7;
      sfr.bit_val <= 1'b1;
      @(posedge clk);
      sfr.bit_wr <= 1'b0;
      rd_chk(8'hA8, 8'h80);
      $display("register access done");
      end_of_test();
   end
endmodule : two_level_irq_controller_tb
`default_nettype wire
